// >>> logic/fds_status_if.sv
// Purpose: Drive-side status, index, stepping and write gating logic
// Assumes: All inputs synchronous to i_clk; interface pins active low
// Notes:   Registers reached over a plain strobe port, read data next cycle
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
module fds_status_if
    import fds_pkg::*;
#(
    parameter int TRIM_CYC  = FDS_TRIM_CYC,
    parameter int INDEX_CYC = FDS_INDEX_CYC
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    output logic            o_irq,
    // Drive sensors
    input  wire logic       i_index_hole,
    input  wire logic       i_index2_hole,
    input  wire logic       i_protect_sense,
    input  wire logic       i_track0_sense,
    input  wire logic       i_lever_open,
    input  wire logic       i_speed_ok,
    input  wire logic       i_read_pulse,
    // Host control lines, active low
    input  wire logic [3:0] i_unit_sel_n,
    input  wire logic       i_motor_off_n,
    input  wire logic       i_step_n,
    input  wire logic       i_dir_in_n,
    input  wire logic       i_wr_gate_n,
    input  wire logic       i_wr_data_n,
    // Host status lines, active low
    output logic            o_index_n,
    output logic            o_wr_prot_n,
    output logic            o_track0_n,
    output logic            o_two_sided_n,
    output logic            o_ready_n,
    output logic            o_disk_chg_n,
    output logic            o_read_data_n,
    // Drive actuators
    output logic            o_motor_en,
    output logic      [1:0] o_phase,
    output logic            o_wr_enable,
    output logic            o_wr_toggle,
    output logic            o_trim_erase
);
    // --------------------------------------------------------------
    // Registers and selection
    // --------------------------------------------------------------
    logic [2:0]  ctrl_q;
    logic [2:0]  stat_q;
    logic [2:0]  mask_q;
    logic [2:0]  ev;
    logic        sel;
    logic        sel_q;
    logic        prot;

    // Pick one of the four shared select lines
    assign sel  = ~i_unit_sel_n[ctrl_q[FDS_CTRL_UNIT_LSB +: 2]];
    // Override strap lets a protected disk be written
    assign prot = i_protect_sense & ~ctrl_q[FDS_CTRL_OVRD_BIT];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_q <= FDS_CTRL_RST;
            mask_q <= FDS_MASK_RST;
        end else if (i_wr && i_addr == FDS_CTRL_OFS) begin
            ctrl_q <= i_wdata[2:0];
        end else if (i_wr && i_addr == FDS_MASK_OFS) begin
            mask_q <= i_wdata[2:0];
        end
    end

    // --------------------------------------------------------------
    // Index pulse shaper
    // --------------------------------------------------------------
    logic        hole_q;
    logic [15:0] idx_cnt_q;

    // Edge of the hole starts exactly one fixed-width pulse
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hole_q    <= 1'b0;
            idx_cnt_q <= 16'h0000;
        end else begin
            hole_q <= i_index_hole;
            if (i_index_hole && !hole_q) begin
                idx_cnt_q <= 16'(INDEX_CYC);
            end else if (idx_cnt_q != 16'h0000) begin
                idx_cnt_q <= idx_cnt_q - 16'h0001;
            end
        end
    end

    // --------------------------------------------------------------
    // Media status latches
    // --------------------------------------------------------------
    logic lever_q;
    logic two_q;
    logic chg_q;
    logic rep_q;
    logic prot_q;

    // Second hole marks a two-sided disk until the lever opens
    always_ff @(posedge i_clk) begin
        if (i_rst || i_lever_open) begin
            two_q <= 1'b0;
        end else if (i_index2_hole) begin
            two_q <= 1'b1;
        end
    end

    // Lever open sets; deselect clears only a reported change.
    // A new open in the deselect cycle still wins.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lever_q <= 1'b0;
            sel_q   <= 1'b0;
            chg_q   <= 1'b0;
            rep_q   <= 1'b0;
        end else begin
            lever_q <= i_lever_open;
            sel_q   <= sel;
            if (i_lever_open && !lever_q) begin
                chg_q <= 1'b1;
                rep_q <= 1'b0;
            end else if (sel_q && !sel && rep_q) begin
                chg_q <= 1'b0;
                rep_q <= 1'b0;
            end else if (sel && chg_q) begin
                rep_q <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // Positioner
    // --------------------------------------------------------------
    logic       step_q;
    logic [1:0] phase_q;
    logic       busy;

    // One phase per step edge; inward counts up, outward down.
    // Steps are dropped, not queued, while writing.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            step_q  <= 1'b1;
            phase_q <= 2'h0;
        end else begin
            step_q <= i_step_n;
            if (step_q && !i_step_n && !busy) begin
                phase_q <= i_dir_in_n ? phase_q - 2'h1 : phase_q + 2'h1;
            end
        end
    end

    // --------------------------------------------------------------
    // Write and trim erase control
    // --------------------------------------------------------------
    logic        wen;
    logic [19:0] trim_cnt_q;
    logic        trim_q;
    logic        wdat_q;
    logic        wtog_q;

    // Write path needs select, gate and an unprotected disk or the override bit set
    assign wen  = sel & ~i_wr_gate_n & ~prot;
    assign busy = sel & ~i_wr_gate_n;

    // Trim erase waits behind the write gap before switching on
    always_ff @(posedge i_clk) begin
        if (i_rst || !wen) begin
            trim_cnt_q <= 20'h00000;
            trim_q     <= 1'b0;
        end else if (trim_cnt_q == 20'(TRIM_CYC - 1)) begin
            trim_q <= 1'b1;
        end else begin
            trim_cnt_q <= trim_cnt_q + 20'h00001;
        end
    end

    // Waveform flips on each leading data edge of the FM stream
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wdat_q <= 1'b1;
            wtog_q <= 1'b0;
        end else begin
            wdat_q <= i_wr_data_n;
            if (wen && wdat_q && !i_wr_data_n) begin
                wtog_q <= ~wtog_q;
            end
        end
    end

    // --------------------------------------------------------------
    // Interface outputs
    // --------------------------------------------------------------
    // All status levels except o_index_n registered so the cable sees no glitches
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wr_prot_n   <= 1'b1;
            o_track0_n    <= 1'b1;
            o_two_sided_n <= 1'b1;
            o_ready_n     <= 1'b1;
            o_disk_chg_n  <= 1'b1;
            o_read_data_n <= 1'b1;
        end else begin
            o_wr_prot_n   <= ~i_protect_sense;
            o_track0_n    <= ~(i_track0_sense && phase_q == 2'h0);
            o_two_sided_n <= ~(sel & two_q);
            o_ready_n     <= ~(sel & i_speed_ok & i_motor_off_n);
            o_disk_chg_n  <= ~(sel & chg_q);
            o_read_data_n <= ~(sel & i_read_pulse & ~busy);
        end
    end

    assign o_index_n    = ~(idx_cnt_q != 16'h0000);
    assign o_motor_en   = i_motor_off_n;
    assign o_phase      = phase_q;
    assign o_wr_enable  = wen;
    assign o_wr_toggle  = wtog_q;
    assign o_trim_erase = trim_q;

    // --------------------------------------------------------------
    // Events, interrupt and read-back
    // --------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        prot_q <= i_rst ? 1'b0 : i_protect_sense;
    end

    assign ev[FDS_EV_INDEX] = i_index_hole & ~hole_q;
    assign ev[FDS_EV_LEVER] = i_lever_open & ~lever_q;
    assign ev[FDS_EV_PROT]  = i_protect_sense ^ prot_q;

    // Read clears, but an event in the same cycle survives
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stat_q <= 3'h0;
        end else if (i_rd && i_addr == FDS_STAT_OFS) begin
            stat_q <= ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    assign o_irq = |(stat_q & mask_q);

    always_ff @(posedge i_clk) begin
        if (i_rst || !i_rd) begin
            o_rdata <= 8'h00;
        end else begin
            unique case (i_addr)
                FDS_CTRL_OFS:  o_rdata <= {5'h00, ctrl_q};
                FDS_STAT_OFS:  o_rdata <= {5'h00, stat_q};
                FDS_MASK_OFS:  o_rdata <= {5'h00, mask_q};
                FDS_STATE_OFS: o_rdata <= {2'h0, trim_q, busy, two_q,
                                           chg_q, phase_q};
                default:       o_rdata <= 8'h00;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    a_index_one_pulse: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $fell(o_index_n) |->
            $past(ev[FDS_EV_INDEX]) ##0 !o_index_n [*8])
        else $error("index pulse too short");
    a_prot_blocks_wr: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_protect_sense && !ctrl_q[FDS_CTRL_OVRD_BIT]) |-> !o_wr_enable)
        else $error("write enabled on protected disk");
    a_track0_home: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !o_track0_n |-> $past(i_track0_sense) && $past(phase_q) == 2'h0)
        else $error("track zero without home phase");
    a_two_side_sel: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !o_two_sided_n |-> $past(sel) && $past(two_q))
        else $error("two-sided while deselected or unseen");
    a_ready_gate: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !o_ready_n |-> $past(sel) && $past(i_speed_ok))
        else $error("ready without select and speed");
    a_chg_on_open: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (ev[FDS_EV_LEVER] && sel) ##1 sel |=> !o_disk_chg_n)
        else $error("lever open not reported");
    a_step_one_phase: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $changed(phase_q) |->
            (phase_q - $past(phase_q) == 2'h1) ||
            ($past(phase_q) - phase_q == 2'h1))
        else $error("phase moved by more than one");
    a_no_step_wr: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $past(busy) |-> $stable(phase_q))
        else $error("stepped during write");
    a_trim_delay: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_trim_erase) |-> trim_cnt_q == 20'(TRIM_CYC - 1))
        else $error("trim erase at wrong time");
    a_desel_quiet: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !$past(sel) |-> o_ready_n && o_two_sided_n && o_disk_chg_n)
        else $error("gated output active while deselected");
endmodule

// >>> logic/fds_pkg.sv
// Purpose: Constants for the flexible disk drive status interface
// Assumes: 250 MHz core clock, active-low interface levels
// Notes:   Offsets are byte addresses on the plain register port
package fds_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [3:0] FDS_CTRL_OFS   = 4'h0;
    localparam logic [3:0] FDS_STAT_OFS   = 4'h4;
    localparam logic [3:0] FDS_MASK_OFS   = 4'h8;
    localparam logic [3:0] FDS_STATE_OFS  = 4'hC;
    // CTRL fields
    localparam int FDS_CTRL_UNIT_LSB = 0;   // Two bits, select line index
    localparam int FDS_CTRL_OVRD_BIT = 2;   // Protect sensor override
    localparam logic [2:0] FDS_CTRL_RST = 3'h0;
    // Event bits, shared by STAT and MASK
    localparam int FDS_EV_INDEX = 0;
    localparam int FDS_EV_LEVER = 1;
    localparam int FDS_EV_PROT  = 2;
    localparam int FDS_EV_W     = 3;
    localparam logic [2:0] FDS_MASK_RST = 3'h0;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int FDS_CLK_MHZ     = 250;
    localparam int FDS_TRIM_US     = 190;
    localparam int FDS_TRIM_CYC    = FDS_TRIM_US * FDS_CLK_MHZ;
    localparam int FDS_INDEX_NS    = 200;
    localparam int FDS_INDEX_CYC   = (FDS_INDEX_NS * FDS_CLK_MHZ) / 1000;
endpackage

// >>> dv/fds_host_model.sv
// Purpose: Host controller model driving the drive's control lines
// Assumes: Control lines active low, changed by NBA after rising edges
// Notes:   Write current switch stays high; traffic stays below track 43
`timescale 1ns/1ps
module fds_host_model (
    // Clock
    input  wire logic       i_clk,
    // Control lines toward the drive
    output logic      [3:0] o_sel_n,
    output logic            o_motor_off_n,
    output logic            o_step_n,
    output logic            o_dir_in_n,
    output logic            o_wr_gate_n,
    output logic            o_wr_data_n
);
    // ----------------------------------------------------------
    // Idle levels
    // ----------------------------------------------------------
    // All lines false, so a quiet host looks like a loose cable
    initial begin
        o_sel_n       = 4'hF;
        o_motor_off_n = 1'b1;
        o_step_n      = 1'b1;
        o_dir_in_n    = 1'b1;
        o_wr_gate_n   = 1'b1;
        o_wr_data_n   = 1'b1;
    end
    // ----------------------------------------------------------
    // Host requests
    // ----------------------------------------------------------
    // Host alone drives select, gate and data lines
    task automatic sel(input logic [3:0] v);
        @(posedge i_clk) o_sel_n <= v;
    endtask
    task automatic motor(input logic v);
        @(posedge i_clk) o_motor_off_n <= v;
    endtask
    task automatic gate(input logic on);
        @(posedge i_clk) o_wr_gate_n <= ~on;
    endtask
    // One cycle low; the next call waits an edge, so high stays >= 1
    task automatic step(input logic inw);
        @(posedge i_clk) o_step_n <= 1'b0;
        o_dir_in_n <= ~inw;
        @(posedge i_clk) o_step_n <= 1'b1;
    endtask
    // Double-frequency cell: clock pulse, then data pulse if one
    task automatic fm_bit(input logic b);
        @(posedge i_clk) o_wr_data_n <= 1'b0;
        @(posedge i_clk) o_wr_data_n <= 1'b1;
        @(posedge i_clk) o_wr_data_n <= ~b;
        @(posedge i_clk) o_wr_data_n <= 1'b1;
    endtask
endmodule

// >>> dv/fds_status_if_tb.sv
// Purpose: Self-checking bench for the drive status interface
// Assumes: 250 MHz clock, trim delay shortened to keep the run short
// Notes:   Random step directions come from a fixed seed
`timescale 1ns/1ps
module fds_status_if_tb;
    import fds_pkg::*;
    localparam int TRIM = 20;
    logic i_clk, i_rst;
    logic [3:0] i_addr, sel_n;
    logic [7:0] i_wdata, o_rdata;
    logic i_wr, i_rd, i_index_hole, i_index2_hole;
    logic i_protect_sense, i_track0_sense, i_lever_open;
    logic i_speed_ok, i_read_pulse;
    logic mot_n, stp_n, dir_n, gate_n, wd_n, o_irq, o_index_n;
    logic o_wr_prot_n, o_track0_n, o_two_sided_n, o_ready_n, o_disk_chg_n;
    logic o_read_data_n, o_motor_en, o_wr_enable, o_wr_toggle, o_trim_erase;
    logic [1:0] o_phase, ph;
    logic t;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, n;
    // ----------------------------------------------------------
    // Clock, host model and design
    // ----------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    fds_host_model host (.i_clk(i_clk), .o_sel_n(sel_n),
        .o_motor_off_n(mot_n), .o_step_n(stp_n), .o_dir_in_n(dir_n),
        .o_wr_gate_n(gate_n), .o_wr_data_n(wd_n));
    fds_status_if #(.TRIM_CYC(TRIM)) dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_irq(o_irq), .i_index_hole(i_index_hole),
        .i_index2_hole(i_index2_hole), .i_protect_sense(i_protect_sense),
        .i_track0_sense(i_track0_sense), .i_lever_open(i_lever_open),
        .i_speed_ok(i_speed_ok), .i_read_pulse(i_read_pulse),
        .i_unit_sel_n(sel_n), .i_motor_off_n(mot_n), .i_step_n(stp_n),
        .i_dir_in_n(dir_n), .i_wr_gate_n(gate_n), .i_wr_data_n(wd_n),
        .o_index_n(o_index_n), .o_wr_prot_n(o_wr_prot_n),
        .o_track0_n(o_track0_n), .o_two_sided_n(o_two_sided_n),
        .o_ready_n(o_ready_n), .o_disk_chg_n(o_disk_chg_n),
        .o_read_data_n(o_read_data_n), .o_motor_en(o_motor_en),
        .o_phase(o_phase), .o_wr_enable(o_wr_enable),
        .o_wr_toggle(o_wr_toggle), .o_trim_erase(o_trim_erase));
    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    // Compare, count, report at once
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Land one ns past the edge so registered updates have settled
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_clk) i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk) i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    function automatic logic [1:0] nxt(logic [1:0] p, logic inw);
        return inw ? p + 2'h1 : p - 2'h1;
    endfunction
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Run is a few hundred cycles; the ceiling only catches a hang
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        // Idle, deselected host and empty drive while reset is held
        {i_rst, i_wr, i_rd, i_addr, i_wdata} <= {3'b100, 12'h000};
        {i_index_hole, i_index2_hole, i_protect_sense} <= 3'h0;
        {i_track0_sense, i_lever_open, i_speed_ok, i_read_pulse} <= 4'h0;
        void'($urandom(3));
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        tick(1);
        chk({o_index_n, o_ready_n, o_disk_chg_n, o_phase}, 8'h1C);
        rd(FDS_CTRL_OFS, 8'h00);
        rd(FDS_MASK_OFS, 8'h00);
        rd(4'h2, 8'h00);
        wr(FDS_STAT_OFS, 8'hFF);
        rd(FDS_STAT_OFS, 8'h00);
        $display("test registers done");
        // Line choice follows the control field
        wr(FDS_CTRL_OFS, 8'h02);
        @(posedge i_clk) i_speed_ok <= 1'b1;
        host.sel(4'hB);
        tick(1);
        chk(o_ready_n, 1'b0);
        chk(o_motor_en, 1'b1);
        host.sel(4'hE);
        tick(1);
        chk(o_ready_n, 1'b1);
        wr(FDS_CTRL_OFS, 8'h00);
        tick(1);
        chk(o_ready_n, 1'b0);
        host.motor(1'b0);
        tick(1);
        chk({o_motor_en, o_ready_n}, 8'h01);
        host.motor(1'b1);
        $display("test select done");
        // Index pulse length and a single pulse per hole
        wr(FDS_MASK_OFS, 8'h01);
        // Count from the first edge that sees the hole, so no cycle is lost
        @(posedge i_clk) i_index_hole <= 1'b1;
        n = 0;
        for (int i = 0; i < 80; i++) begin
            @(posedge i_clk);
            if (i == 2) i_index_hole <= 1'b0;
            #1;
            if (o_index_n === 1'b0) n++;
        end
        chk(8'(n), 8'(FDS_INDEX_CYC));
        chk(o_irq, 1'b1);
        rd(FDS_STAT_OFS, 8'h01);
        tick(1);
        chk(o_irq, 1'b0);
        $display("test index done");
        // Home only with phase at zero; random step directions
        @(posedge i_clk) i_track0_sense <= 1'b1;
        tick(1);
        chk(o_track0_n, 1'b0);
        ph = 2'h0;
        for (int i = 0; i < 9; i++) begin
            t = (i == 0) ? 1'b1 : 1'($urandom % 2);
            host.step(t);
            tick(1);
            ph = nxt(ph, t);
            chk(o_phase, ph);
        end
        tick(1);
        chk(o_track0_n, (ph == 2'h0) ? 1'b0 : 1'b1);
        $display("test stepping done");
        // Second hole and the change latch
        // Latch set at the first edge, status one edge later
        @(posedge i_clk) i_index2_hole <= 1'b1;
        tick(2);
        chk(o_two_sided_n, 1'b0);
        host.sel(4'hF);
        @(posedge i_clk) {i_lever_open, i_index2_hole} <= 2'b10;
        repeat (2) @(posedge i_clk);
        i_lever_open <= 1'b0;
        tick(1);
        chk({o_disk_chg_n, o_two_sided_n, o_ready_n}, 8'h07);
        host.sel(4'hE);
        tick(1);
        chk({o_disk_chg_n, o_two_sided_n}, 8'h01);
        host.sel(4'hF);
        host.sel(4'hE);
        tick(2);
        chk(o_disk_chg_n, 1'b1);
        // Lever opened while selected is reported without a reselect
        @(posedge i_clk) i_lever_open <= 1'b1;
        @(posedge i_clk) i_lever_open <= 1'b0;
        tick(2);
        chk(o_disk_chg_n, 1'b0);
        rd(FDS_STAT_OFS, 8'h02);
        $display("test change done");
        // Writing: read path muted, steps blocked, trim delay
        @(posedge i_clk) i_read_pulse <= 1'b1;
        tick(2);
        chk(o_read_data_n, 1'b0);
        host.gate(1'b1);
        #1 chk(o_wr_enable, 1'b1);
        // Trim must still be off one cycle before the delay ends
        tick(TRIM - 1);
        chk({o_trim_erase, o_read_data_n}, 8'h01);
        tick(1);
        chk(o_trim_erase, 1'b1);
        ph = o_phase;
        host.step(1'b1);
        tick(1);
        chk(o_phase, ph);
        // Trim, busy, no second side, change latched, phase
        rd(FDS_STATE_OFS, {4'h3, 2'h1, ph});
        t = o_wr_toggle;
        host.fm_bit(1'b1);
        tick(1);
        chk(o_wr_toggle, t);
        host.fm_bit(1'b0);
        tick(1);
        chk(o_wr_toggle, {7'h00, ~t});
        // Dropping the gate ends trim at the next edge
        host.gate(1'b0);
        tick(1);
        chk(o_trim_erase, 1'b0);
        host.gate(1'b1);
        @(posedge i_clk) i_protect_sense <= 1'b1;
        tick(1);
        chk({o_wr_enable, o_wr_prot_n}, 8'h00);
        wr(FDS_CTRL_OFS, 8'h04);
        tick(1);
        chk({o_wr_enable, o_wr_prot_n}, 8'h02);
        host.gate(1'b0);
        tick(2);
        chk(o_trim_erase, 1'b0);
        $display("test write done");
        close_out();
    end
endmodule
